// ---- core/mber_pkg.sv ----
package mber_pkg;

  // supported function codes
  localparam logic [7:0] FC_READ_INPUTS  = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INREG   = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI  = 8'h10;

  // fault codes of the error frame
  localparam logic [7:0] FAULT_BASE          = 8'h80;
  localparam logic [7:0] FAULT_READ_INPUTS   = 8'h82;
  localparam logic [7:0] FAULT_READ_HOLDING  = 8'h83;
  localparam logic [7:0] FAULT_READ_INREG    = 8'h84;
  localparam logic [7:0] FAULT_WRITE_SINGLE  = 8'h90;
  localparam logic [7:0] FAULT_WRITE_MULTI   = 8'h86;

  // exception codes
  localparam logic [7:0] EXC_FUNC   = 8'h01;
  localparam logic [7:0] EXC_ADDR   = 8'h02;
  localparam logic [7:0] EXC_QTY    = 8'h03;
  localparam logic [7:0] EXC_SERVER = 8'h04;

  // quantity bounds
  localparam logic [15:0] QTY_MIN       = 16'h0001;
  localparam logic [15:0] QTY_READ_MAX  = 16'h07D0;
  localparam logic [15:0] QTY_WRITE_MAX = 16'h007B;

  // address map regions, inclusive bounds in request address units
  localparam int NUM_REGIONS = 6;
  localparam logic [15:0] REGION_LO [NUM_REGIONS] = '{
    16'h0001, 16'h03E9, 16'h0001, 16'h07D1, 16'h1388, 16'h0001};
  localparam logic [15:0] REGION_HI [NUM_REGIONS] = '{
    16'h0080, 16'h05E8, 16'h0030, 16'h07F0, 16'h138D, 16'h0020};

  // which regions each function may reach (bit i = region i)
  localparam logic [5:0] MASK_READ_INPUTS  = 6'h03;
  localparam logic [5:0] MASK_READ_HOLDING = 6'h1E;
  localparam logic [5:0] MASK_READ_INREG   = 6'h20;
  localparam logic [5:0] MASK_WRITE        = 6'h0A;

  // request as handed over by the frame parser
  typedef struct packed {
    logic [7:0]  funcCode;
    logic [15:0] startAddr;
    logic [15:0] quantity;
    logic [7:0]  byteCount;
  } mber_req_s;

  // two-byte error frame
  typedef struct packed {
    logic [7:0] faultCode;
    logic [7:0] excCode;
  } mber_exc_s;

endpackage

// ---- core/mber_range_check.sv ----
`timescale 1ns/1ps
module mber_range_check (
  // requested range
  input  wire logic [15:0] startAddr,
  input  wire logic [15:0] quantity,
  // region selection
  input  wire logic [5:0]  regionMask,
  input  wire logic [5:0]  regionEnable,
  // result
  output logic             rangeOk
);

  logic [16:0] lastAddr;
  logic [5:0]  regionHit;

  // last address of the range; 17 bits so a wrap cannot look valid
  assign lastAddr = {1'b0, startAddr} + {1'b0, quantity} - 17'h0_0001;

  // the whole range must sit inside one allowed, enabled region
  for (genvar i = 0; i < mber_pkg::NUM_REGIONS; i++) begin : g_region
    assign regionHit[i] = regionMask[i] && regionEnable[i] &&
                          (startAddr >= mber_pkg::REGION_LO[i]) &&
                          (lastAddr <= {1'b0, mber_pkg::REGION_HI[i]});
  end

  assign rangeOk = (startAddr != 16'h0000) && (|regionHit);

endmodule

// ---- core/mber_responder.sv ----
`timescale 1ns/1ps
module mber_responder (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // request from the frame parser
  input  wire logic                reqValid,
  input  wire mber_pkg::mber_req_s reqIn,
  output logic                     reqReady,
  // region enables from the device configuration
  input  wire logic [5:0]          regionEnable,
  // outcome
  output logic                     excValid,
  output mber_pkg::mber_exc_s      excOut,
  output logic                     readGo,
  output logic                     writeGo,
  output logic                     echoValid,
  output mber_pkg::mber_req_s      cmdOut
);

  typedef enum logic [0:0] {MBER_IDLE, MBER_CHECK} mber_state_e;

  mber_state_e         state_reg,     state_next;
  mber_pkg::mber_req_s reqHeld_reg,   reqHeld_next;
  logic                ready_reg,     ready_next;
  logic                excValid_reg,  excValid_next;
  mber_pkg::mber_exc_s exc_reg,       exc_next;
  logic                readGo_reg,    readGo_next;
  logic                writeGo_reg,   writeGo_next;
  logic                echo_reg,      echo_next;

  // request classification
  logic                supported;
  logic                isWrite;
  logic [7:0]          faultCode;
  logic [5:0]          regionMask;
  logic [15:0]         qtyMax;
  logic [15:0]         checkQty;
  logic                qtyOk;
  logic                rangeOk;

  // decode the held function code into its checks
  always_comb begin
    supported  = 1'b1;
    isWrite    = 1'b0;
    faultCode  = mber_pkg::FAULT_BASE + reqHeld_reg.funcCode;
    regionMask = 6'h00;
    qtyMax     = mber_pkg::QTY_READ_MAX;
    checkQty   = reqHeld_reg.quantity;
    case (reqHeld_reg.funcCode)
      mber_pkg::FC_READ_INPUTS: begin
        faultCode  = mber_pkg::FAULT_READ_INPUTS;
        regionMask = mber_pkg::MASK_READ_INPUTS;
      end
      mber_pkg::FC_READ_HOLDING: begin
        faultCode  = mber_pkg::FAULT_READ_HOLDING;
        regionMask = mber_pkg::MASK_READ_HOLDING;
      end
      mber_pkg::FC_READ_INREG: begin
        faultCode  = mber_pkg::FAULT_READ_INREG;
        regionMask = mber_pkg::MASK_READ_INREG;
      end
      mber_pkg::FC_WRITE_SINGLE: begin
        // quantity field carries the value here; one register is targeted
        isWrite    = 1'b1;
        faultCode  = mber_pkg::FAULT_WRITE_SINGLE;
        regionMask = mber_pkg::MASK_WRITE;
        checkQty   = mber_pkg::QTY_MIN;
      end
      mber_pkg::FC_WRITE_MULTI: begin
        isWrite    = 1'b1;
        faultCode  = mber_pkg::FAULT_WRITE_MULTI;
        regionMask = mber_pkg::MASK_WRITE;
        qtyMax     = mber_pkg::QTY_WRITE_MAX;
      end
      default: supported = 1'b0;
    endcase
  end

  // quantity window; byte count compare only matters for the multi write
  // read and write quantity bounds
  always_comb begin
    qtyOk = (checkQty >= mber_pkg::QTY_MIN) && (checkQty <= qtyMax);
    if (reqHeld_reg.funcCode == mber_pkg::FC_WRITE_MULTI) begin
      qtyOk = qtyOk &&
        ({1'b0, reqHeld_reg.byteCount} == {reqHeld_reg.quantity[7:0], 1'b0});
    end
  end

  // address map lookup over the held range
  mber_range_check u_range (
    .startAddr    (reqHeld_reg.startAddr),
    .quantity     (checkQty),
    .regionMask   (regionMask),
    .regionEnable (regionEnable),
    .rangeOk      (rangeOk)
  );

  // next state; one request at a time, answer one cycle after it is taken
  always_comb begin
    state_next    = state_reg;
    reqHeld_next  = reqHeld_reg;
    ready_next    = ready_reg;
    excValid_next = 1'b0;
    exc_next      = exc_reg;
    readGo_next   = 1'b0;
    writeGo_next  = 1'b0;
    echo_next     = 1'b0;
    unique case (state_reg)
      MBER_IDLE: begin
        if (reqValid && ready_reg) begin
          reqHeld_next = reqIn;
          ready_next   = 1'b0;
          state_next   = MBER_CHECK;
        end
      end
      MBER_CHECK: begin
        ready_next = 1'b1;
        state_next = MBER_IDLE;
        if (!supported) begin
          excValid_next = 1'b1;
          exc_next = '{faultCode: faultCode, excCode: mber_pkg::EXC_FUNC};
        end else if (!qtyOk) begin
          excValid_next = 1'b1;
          exc_next = '{faultCode: faultCode, excCode: mber_pkg::EXC_QTY};
        end else if (!rangeOk) begin
          excValid_next = 1'b1;
          exc_next = '{faultCode: faultCode, excCode: mber_pkg::EXC_ADDR};
        end else if (isWrite) begin
          writeGo_next = 1'b1;
          echo_next = (reqHeld_reg.funcCode == mber_pkg::FC_WRITE_SINGLE);
        end else begin
          readGo_next = 1'b1;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= MBER_IDLE;
      reqHeld_reg  <= '0;
      ready_reg    <= 1'b1;
      excValid_reg <= 1'b0;
      exc_reg      <= '0;
      readGo_reg   <= 1'b0;
      writeGo_reg  <= 1'b0;
      echo_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      reqHeld_reg  <= reqHeld_next;
      ready_reg    <= ready_next;
      excValid_reg <= excValid_next;
      exc_reg      <= exc_next;
      readGo_reg   <= readGo_next;
      writeGo_reg  <= writeGo_next;
      echo_reg     <= echo_next;
    end
  end

  // outputs straight from flops; cmdOut holds until the next request
  assign reqReady  = ready_reg;
  assign excValid  = excValid_reg;
  assign excOut    = exc_reg;
  assign readGo    = readGo_reg;
  assign writeGo   = writeGo_reg;
  assign echoValid = echo_reg;
  assign cmdOut    = reqHeld_reg;

  // checks on the outcome
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  answer_timing_a: assert property (
    reqValid && reqReady |=> ##1 (excValid || readGo || writeGo))
    else $error("no outcome one cycle after request");

  single_outcome_a: assert property (
    $onehot0({excValid, readGo, writeGo}))
    else $error("more than one outcome at once");

  unsupported_func_a: assert property (
    excValid && !(cmdOut.funcCode inside {8'h02, 8'h03, 8'h04, 8'h06,
    8'h10}) |-> excOut.excCode == 8'h01 &&
    excOut.faultCode == 8'(8'h80 + cmdOut.funcCode))
    else $error("wrong frame for unsupported function");

  inputs_fault_a: assert property (
    excValid && cmdOut.funcCode == 8'h02 |->
    excOut.faultCode == 8'h82 && excOut.excCode inside {8'h02, 8'h03})
    else $error("bad discrete input fault frame");

  holding_fault_a: assert property (
    excValid && cmdOut.funcCode == 8'h03 |-> excOut.faultCode == 8'h83)
    else $error("bad holding fault code");

  inreg_fault_a: assert property (
    excValid && cmdOut.funcCode == 8'h04 |-> excOut.faultCode == 8'h84)
    else $error("bad input register fault code");

  single_fault_a: assert property (
    excValid && cmdOut.funcCode == 8'h06 |->
    excOut.faultCode == 8'h90 && excOut.excCode == 8'h02)
    else $error("bad single write fault frame");

  multi_fault_a: assert property (
    excValid && cmdOut.funcCode == 8'h10 |-> excOut.faultCode == 8'h86)
    else $error("bad multi write fault code");

  read_qty_a: assert property (
    readGo |-> cmdOut.quantity >= 16'h0001 && cmdOut.quantity <= 16'h07D0)
    else $error("read passed with bad quantity");

  byte_count_a: assert property (
    writeGo && cmdOut.funcCode == 8'h10 |-> cmdOut.quantity <= 16'h007B &&
    {1'b0, cmdOut.byteCount} == {cmdOut.quantity[7:0], 1'b0})
    else $error("multi write passed with bad counts");

  addr_zero_a: assert property (
    (readGo || writeGo) |-> cmdOut.startAddr != 16'h0000)
    else $error("address zero accepted");

  write_valid_a: assert property (
    writeGo |-> rangeOk && $past(state_reg) == MBER_CHECK)
    else $error("write released without valid range");

  no_server_exc_a: assert property (
    excValid |-> excOut.excCode != 8'h04)
    else $error("server exception raised");

  echo_single_a: assert property (
    echoValid |-> writeGo && cmdOut.funcCode == 8'h06)
    else $error("echo without single write");

  cov_unsupported_c: cover property (excValid && excOut.excCode == 8'h01);
  cov_addr_c:        cover property (excValid && excOut.excCode == 8'h02);
  cov_qty_c:         cover property (excValid && excOut.excCode == 8'h03);
  cov_write_c:       cover property (writeGo ##1 reqValid && reqReady);

endmodule

// ---- verification/mber_client_model.sv ----
`timescale 1ns/1ps
// client stand-in: hands one whole request word per transfer
module mber_client_model (
  // clock
  input  wire logic           clock,
  // request handshake
  input  wire logic           reqReady,
  output logic                reqValid,
  output mber_pkg::mber_req_s reqIn
);
  // idle at time zero
  initial begin
    reqValid = 1'b0;
    reqIn    = '0;
  end

  // one-based address; address zero is refused
  // caller stands at a falling edge; the word is held until taken, and
  // the start address goes out as given, high byte in the upper half
  task automatic send(input mber_pkg::mber_req_s req);
    reqValid = 1'b1;
    reqIn    = req;
    do @(posedge clock); while (reqReady !== 1'b1);
    @(negedge clock);
  endtask

  // a released word shows its inverse so no stale copy can pass
  task automatic release_bus();
    reqValid = 1'b0;
    reqIn    = ~reqIn;
  endtask
endmodule

// ---- verification/tb_modbus_exception_responder.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  failures++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_modbus_exception_responder;
  // one request and its outcome: kind 0 read, 1 write, 2 error frame
  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0]  bc;
    logic [5:0]  en;
    logic [1:0]  kind;
    logic [7:0]  exc;
  } mber_row_s;
  // one outcome pulse as seen at the ports
  typedef struct packed {
    logic [3:0]          flags;
    mber_pkg::mber_exc_s frame;
    mber_pkg::mber_req_s cmd;
  } mber_seen_s;
  localparam logic [1:0] KR = 2'h0;
  localparam logic [1:0] KW = 2'h1;
  localparam logic [1:0] KE = 2'h2;

  logic                clock, rst_n, reqValid, reqReady;
  logic                excValid, readGo, writeGo, echoValid;
  logic [5:0]          regionEnable;
  mber_pkg::mber_req_s reqIn, cmdOut;
  mber_pkg::mber_exc_s excOut;
  mber_row_s           rows [29];
  mber_seen_s          seen [$];
  mber_seen_s          got;
  int                  failures, check_count;

  mber_responder u_mber_responder (
    .clock(clock), .rst_n(rst_n), .reqValid(reqValid), .reqIn(reqIn),
    .reqReady(reqReady), .regionEnable(regionEnable),
    .excValid(excValid), .excOut(excOut), .readGo(readGo),
    .writeGo(writeGo), .echoValid(echoValid), .cmdOut(cmdOut));
  mber_client_model u_mber_client_model (
    .clock(clock), .reqReady(reqReady), .reqValid(reqValid),
    .reqIn(reqIn));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // log each outcome pulse; the rising edge still sees the pulse cycle
  always @(posedge clock) begin
    if (excValid === 1'b1 || readGo === 1'b1 || writeGo === 1'b1)
      seen.push_back({excValid, readGo, writeGo, echoValid, excOut, cmdOut});
  end

  function automatic logic [7:0] fault_of(input logic [7:0] fc);
    case (fc)
      mber_pkg::FC_READ_INPUTS:  return mber_pkg::FAULT_READ_INPUTS;
      mber_pkg::FC_READ_HOLDING: return mber_pkg::FAULT_READ_HOLDING;
      mber_pkg::FC_READ_INREG:   return mber_pkg::FAULT_READ_INREG;
      mber_pkg::FC_WRITE_SINGLE: return mber_pkg::FAULT_WRITE_SINGLE;
      mber_pkg::FC_WRITE_MULTI:  return mber_pkg::FAULT_WRITE_MULTI;
      default:                   return mber_pkg::FAULT_BASE + fc;
    endcase
  endfunction

  // wait, bounded, for one outcome and compare it with the row
  task automatic expect_row(input mber_row_s r);
    logic [3:0] fl;
    fl = (r.kind == KR) ? 4'h4 : (r.kind == KW) ?
         {3'b001, r.fc == mber_pkg::FC_WRITE_SINGLE} : 4'h8;
    for (int i = 0; i < 6 && seen.size() == 0; i++) @(negedge clock);
    `CHK("outcome count", 1, seen.size()) // one answer
    if (seen.size() > 0) begin
      got = seen.pop_front();
      `CHK("pulses", fl, got.flags) // kind of answer
      `CHK("cmdOut", {r.fc, r.addr, r.qty, r.bc}, got.cmd) // echo
      if (r.kind == KE)
        `CHK("excOut", {fault_of(r.fc), r.exc}, got.frame) // frame
    end
  endtask

  task automatic run_row(input mber_row_s r);
    @(negedge clock);
    regionEnable = r.en;
    u_mber_client_model.send({r.fc, r.addr, r.qty, r.bc});
    `CHK("reqReady busy", 1'b0, reqReady) // one at a time
    u_mber_client_model.release_bus();
    expect_row(r);
    repeat (3) @(negedge clock);
    `CHK("extra pulses", 0, seen.size()) // single pulse
  endtask

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    give_verdict();
  end

  initial begin
    rst_n        = 1'b0;
    regionEnable = 6'h3F;
    failures     = 0;
    check_count  = 0;
    rows = '{
      '{8'h02, 16'h0001, 16'h0001, 8'h00, 6'h3F, KR, 8'h00},
      '{8'h02, 16'h0000, 16'h0001, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h02, 16'h0001, 16'h0000, 8'h00, 6'h3F, KE, 8'h03},
      '{8'h02, 16'h0001, 16'h07D1, 8'h00, 6'h3F, KE, 8'h03},
      '{8'h02, 16'h0001, 16'h07D0, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h02, 16'h0080, 16'h0002, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h02, 16'h0001, 16'h0001, 8'h00, 6'h3E, KE, 8'h02},
      '{8'h03, 16'h0001, 16'h0030, 8'h00, 6'h3F, KR, 8'h00},
      '{8'h03, 16'h0001, 16'h0031, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h03, 16'h0001, 16'h07D1, 8'h00, 6'h3F, KE, 8'h03},
      '{8'h04, 16'h0001, 16'h0020, 8'h00, 6'h3F, KR, 8'h00},
      '{8'h04, 16'h0021, 16'h0001, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h04, 16'h0001, 16'h0000, 8'h00, 6'h1F, KE, 8'h03},
      '{8'h06, 16'h03E9, 16'h0000, 8'h00, 6'h3F, KW, 8'h00},
      '{8'h06, 16'h0000, 16'hBEEF, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h06, 16'h05E9, 16'h0001, 8'h00, 6'h3F, KE, 8'h02},
      '{8'h10, 16'h07D1, 16'h0020, 8'h40, 6'h3F, KW, 8'h00},
      '{8'h10, 16'h03E9, 16'h007B, 8'hF6, 6'h3F, KW, 8'h00},
      '{8'h10, 16'h07D1, 16'h007C, 8'hF8, 6'h3F, KE, 8'h03},
      '{8'h10, 16'h07D1, 16'h0002, 8'h03, 6'h3F, KE, 8'h03},
      '{8'h10, 16'h07F0, 16'h0002, 8'h04, 6'h3F, KE, 8'h02},
      '{8'h10, 16'h0000, 16'h0000, 8'h00, 6'h3F, KE, 8'h03},
      '{8'h01, 16'h0000, 16'h0000, 8'h00, 6'h3F, KE, 8'h01},
      '{8'h05, 16'h0001, 16'h0001, 8'h00, 6'h3F, KE, 8'h01},
      '{8'h7F, 16'h0001, 16'h0001, 8'h00, 6'h3F, KE, 8'h01},
      '{8'h81, 16'h0001, 16'h0001, 8'h00, 6'h3F, KE, 8'h01},
      '{8'h2B, 16'h0001, 16'h0001, 8'h00, 6'h3F, KE, 8'h01},
      '{8'h03, 16'h1388, 16'h0006, 8'h00, 6'h3F, KR, 8'h00},
      '{8'h03, 16'h1388, 16'h0006, 8'h00, 6'h2F, KE, 8'h02}
    };
    // reset state while held
    repeat (12) @(negedge clock);
    `CHK("reqReady in reset", 1'b1, reqReady)
    `CHK("excOut in reset", 16'h0000, excOut)
    `CHK("cmdOut in reset", '0, cmdOut)
    `CHK("pulses in reset", 4'h0, {excValid, readGo, writeGo, echoValid})
    rst_n = 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    // back to back: error then read, second held while refused
    @(negedge clock);
    u_mber_client_model.send({rows[1].fc, rows[1].addr, rows[1].qty, 8'h00});
    u_mber_client_model.send({rows[0].fc, rows[0].addr, rows[0].qty, 8'h00});
    u_mber_client_model.release_bus();
    expect_row(rows[1]);
    expect_row(rows[0]);
    repeat (2) @(negedge clock);
    `CHK("excOut held", 16'h8202, excOut) // frame kept
    // reset in mid-run clears the frame, then work resumes
    rst_n = 1'b0;
    @(negedge clock);
    `CHK("excOut after reset", 16'h0000, excOut)
    `CHK("reqReady after reset", 1'b1, reqReady)
    repeat (11) @(negedge clock);
    rst_n = 1'b1;
    run_row(rows[16]);
    give_verdict();
  end
endmodule
